// File: pecd_pkg.sv
// Package: register map, field positions, reset values and carriers
// Assumes a serial bus engine outside hands over decoded register accesses
package pecd_pkg;

  // Register addresses
  localparam logic [7:0] ADDR_GLOBAL_DRIVE = 8'h02;
  localparam logic [7:0] ADDR_DEVICE_CFG   = 8'h04;
  localparam logic [7:0] ADDR_MASK         = 8'h06;
  localparam logic [7:0] ADDR_DISP_TEST    = 8'h07;
  localparam logic [7:0] ADDR_SEG_FIRST    = 8'h12;
  localparam logic [7:0] ADDR_SEG_LAST     = 8'h1F;

  // Field positions
  localparam int CFG_RUN_BIT    = 0;
  localparam int CFG_INDIV_BIT  = 6;
  localparam int CFG_ARM_BIT    = 7;
  localparam int MASK_ALERT_BIT = 7;
  localparam int DT_ON_BIT      = 0;

  // Widths and counts
  localparam int NUM_MON   = 7;
  localparam int NUM_SEG   = 28;
  localparam int SEG_BASE  = 4;
  localparam int NUM_CREG  = 14;

  // Reset values and fixed codes
  localparam logic [7:0] CFG_RESET    = 8'h00;
  localparam logic [3:0] LEVEL_RESET  = 4'h0;
  localparam logic [6:0] MASK_RESET   = 7'h00;
  localparam logic [3:0] LEVEL_HALF   = 4'h7;
  localparam logic [7:0] CFG_RD_MASK  = 8'hC1;
  localparam logic [7:0] LOW_NIB_MASK = 8'h0F;
  localparam logic [7:0] ZERO_BYTE    = 8'h00;

  // Port mode codes of a port's two configuration bits
  localparam logic [1:0] MODE_LED     = 2'h0;
  localparam logic [1:0] MODE_OUT     = 2'h1;

  // Register access from the serial engine
  typedef struct packed {
    logic       wrStb;
    logic       rdStb;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pecd_access_t;

  // Detector state
  typedef enum logic [2:0] {
    DET_IDLE  = 3'b001,
    DET_WATCH = 3'b010,
    DET_HELD  = 3'b100
  } pecd_det_t;

endpackage

// File: pecd_drive_sel.sv
// Per-port drive selection: on/off and current level for each LED-driver port
// Assumes stored controls arrive as levels from the register block
module pecd_drive_sel
  import pecd_pkg::*;
(
  // Stored controls
  input  wire logic [1:0]           portMode [NUM_SEG],
  input  wire logic [NUM_SEG-1:0]   portData,
  input  wire logic [3:0]           segLevel [NUM_SEG],
  input  wire logic [3:0]           globalLevel,
  input  wire logic                 indivMode,
  input  wire logic                 running,
  input  wire logic                 testOn,
  // Per-port results
  output logic      [NUM_SEG-1:0]   ledOn,
  output logic      [3:0]           ledLevel [NUM_SEG]
);

  // Combine global, per-segment and display-test choices
  always_comb
  begin
    for (int i = 0; i < NUM_SEG; i++)
    begin
      ledOn[i]    = 1'b0;
      ledLevel[i] = indivMode ? segLevel[i] : globalLevel;
      if (portMode[i] == MODE_LED)
      begin
        if (testOn)
        begin
          ledOn[i]    = 1'b1;
          ledLevel[i] = LEVEL_HALF;
        end
        else
          ledOn[i] = running & portData[i];
      end
    end
  end

endmodule

// File: pecd_top.sv
// Configuration, global current, transition detection and display test
// Assumes decoded accesses synchronous to sys_clk; pins already synchronous
module pecd_top
  import pecd_pkg::*;
(
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 arst_n,
  // Register access
  input  wire pecd_access_t         acc,
  output logic      [7:0]           rdata,
  // Port levels and configuration from the port block
  input  wire logic [NUM_MON-1:0]   monitoredPorts,
  input  wire logic [1:0]           portMode [NUM_SEG],
  input  wire logic [NUM_SEG-1:0]   portData,
  // Alert pin port
  output logic                      alertPinPort,
  output logic                      alertPinOe_n,
  // Drive results
  output logic                      shutdown,
  output logic      [NUM_SEG-1:0]   ledOn,
  output logic      [3:0]           ledLevel [NUM_SEG]
);

  //////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic [1:0] rstSync;
  logic       rst_n;

  // Two-stage release of the async reset
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      rstSync <= 2'b00;
    else
      rstSync <= {rstSync[0], 1'b1};
  end
  assign rst_n = rstSync[1];

  //////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [7:0]         cfg;
    logic [3:0]         globalLevel;
    logic [6:0]         mask;
    logic               alert;
    logic [6:0]         snapshot;
    pecd_det_t          det;
    logic               testOn;
    logic [7:0]         rdata;
  } pecd_state_t;

  pecd_state_t st;
  pecd_state_t next_st;
  logic [7:0]  segReg [NUM_CREG];
  logic [3:0]  segLevel [NUM_SEG];
  logic        cfgWr;
  logic        maskAcc;
  logic        armWr;
  logic        diff;
  logic        alertPinEn;

  // Address match helper
  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = (a == target);
  endfunction

  // Segment register index of an address in range
  function automatic logic [3:0] segIdx(input logic [7:0] a);
    logic [7:0] d;
    d = a - ADDR_SEG_FIRST;
    segIdx = d[3:0];
  endfunction

  assign cfgWr   = acc.wrStb & hit(acc.addr, ADDR_DEVICE_CFG);
  assign armWr   = cfgWr & acc.wdata[CFG_ARM_BIT];
  // Any read or write of the mask register clears a held alert
  assign maskAcc = (acc.wrStb | acc.rdStb) & hit(acc.addr, ADDR_MASK);
  // Difference of unmasked monitored ports, whatever their direction
  assign diff    = |((monitoredPorts ^ st.snapshot) & st.mask);
  // Alert pin active when its port is set as output
  assign alertPinEn = (portMode[NUM_SEG-1] == MODE_OUT);

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    next_st = st;
    // Register writes
    if (acc.wrStb)
    begin
      if (hit(acc.addr, ADDR_GLOBAL_DRIVE))
        next_st.globalLevel = acc.wdata[3:0];
      else if (hit(acc.addr, ADDR_DEVICE_CFG))
        next_st.cfg = acc.wdata & CFG_RD_MASK;
      else if (hit(acc.addr, ADDR_MASK))
        next_st.mask = acc.wdata[6:0];
      else if (hit(acc.addr, ADDR_DISP_TEST))
        next_st.testOn = acc.wdata[DT_ON_BIT];
    end
    // Detector
    case (st.det)
      DET_IDLE:
      begin
        next_st.det = DET_IDLE;
      end
      DET_WATCH:
      begin
        if (diff)
        begin
          next_st.alert = 1'b1;
          next_st.det   = DET_HELD;
        end
      end
      DET_HELD:
      begin
        next_st.alert = 1'b1;
        if (maskAcc)
        begin
          next_st.alert = 1'b0;
          next_st.det   = DET_IDLE;
        end
      end
      default:
      begin
        next_st.det = DET_IDLE;
      end
    endcase
    // Mask access while idle keeps the alert clear; a change seen while watching wins
    if (maskAcc && st.det == DET_IDLE)
      next_st.alert = 1'b0;
    // Disarm write stops detection
    if (cfgWr && !acc.wdata[CFG_ARM_BIT] && st.det == DET_WATCH)
      next_st.det = DET_IDLE;
    // Arming write: new snapshot, clear alert, watch
    if (armWr)
    begin
      next_st.snapshot = monitoredPorts;
      next_st.alert    = 1'b0;
      next_st.det      = DET_WATCH;
    end
    // Read data
    next_st.rdata = ZERO_BYTE;
    if (acc.rdStb)
    begin
      if (hit(acc.addr, ADDR_GLOBAL_DRIVE))
        next_st.rdata = {4'h0, st.globalLevel};
      else if (hit(acc.addr, ADDR_DEVICE_CFG))
        next_st.rdata = st.cfg & CFG_RD_MASK;
      else if (hit(acc.addr, ADDR_MASK))
        next_st.rdata = {st.alert, st.mask};
      else if (hit(acc.addr, ADDR_DISP_TEST))
        next_st.rdata = {7'h00, st.testOn};
      else if (acc.addr >= ADDR_SEG_FIRST && acc.addr <= ADDR_SEG_LAST)
        next_st.rdata = segReg[segIdx(acc.addr)];
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st.cfg         <= CFG_RESET;
      st.globalLevel <= LEVEL_RESET;
      st.mask        <= MASK_RESET;
      st.alert       <= 1'b0;
      st.snapshot    <= MASK_RESET;
      st.det         <= DET_IDLE;
      st.testOn      <= 1'b0;
      st.rdata       <= ZERO_BYTE;
    end
    else
      st <= next_st;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Per-segment current registers
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NUM_CREG; i++)
        segReg[i] <= ZERO_BYTE;
    end
    else if (acc.wrStb && acc.addr >= ADDR_SEG_FIRST && acc.addr <= ADDR_SEG_LAST)
      segReg[segIdx(acc.addr)] <= acc.wdata;
  end

  // Low nibble for even segment, high for odd
  always_comb
  begin
    for (int s = 0; s < NUM_SEG; s++)
    begin
      if (s[0])
        segLevel[s] = segReg[s/2][7:4];
      else
        segLevel[s] = segReg[s/2][3:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign rdata        = st.rdata;
  assign shutdown     = ~st.cfg[CFG_RUN_BIT];
  assign alertPinPort = alertPinEn & st.alert;
  assign alertPinOe_n = ~alertPinEn;

  // Drive selection
  pecd_drive_sel u_drive
  (
    .portMode    (portMode),
    .portData    (portData),
    .segLevel    (segLevel),
    .globalLevel (st.globalLevel),
    .indivMode   (st.cfg[CFG_INDIV_BIT]),
    .running     (st.cfg[CFG_RUN_BIT]),
    .testOn      (st.testOn),
    .ledOn       (ledOn),
    .ledLevel    (ledLevel)
  );

endmodule

// File: pecd_sva.sv
// Checker: register, shutdown and alert pin relations at the top ports
// Assumes it is bound into every pecd_top instance
module pecd_sva
  import pecd_pkg::*;
(
  // Clock, reset and bus
  input  wire logic         sys_clk,
  input  wire logic         arst_n,
  input  wire pecd_access_t acc,
  input  wire logic [7:0]   rdata,
  // Pins
  input  wire logic [1:0]   portMode [NUM_SEG],
  input  wire logic         alertPinPort,
  input  wire logic         alertPinOe_n,
  input  wire logic         shutdown
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  logic rdCfg, rdGl, rdMk, mkAcc, wrArm, pinOut;
  ////////////////////////////////////////////////////////////////
  // Decoded accesses
  assign rdCfg  = acc.rdStb && acc.addr == ADDR_DEVICE_CFG;
  assign rdGl   = acc.rdStb && acc.addr == ADDR_GLOBAL_DRIVE;
  assign rdMk   = acc.rdStb && acc.addr == ADDR_MASK;
  assign mkAcc  = (acc.rdStb || acc.wrStb) && acc.addr == ADDR_MASK;
  assign wrArm  = acc.wrStb && acc.addr == ADDR_DEVICE_CFG && acc.wdata[CFG_ARM_BIT];
  assign pinOut = portMode[NUM_SEG-1] == MODE_OUT;
  ////////////////////////////////////////////////////////////////
  a_rdata_idle: assert property (!acc.rdStb |=> rdata == ZERO_BYTE)
    else $error("read data not zero without read");
  a_shut_cfg: assert property (acc.wrStb && acc.addr == ADDR_DEVICE_CFG
    |=> shutdown == !$past(acc.wdata[CFG_RUN_BIT])) else $error("shutdown wrong");
  a_cfg_zero: assert property (rdCfg |=> rdata[5:1] == 5'h0)
    else $error("config unused bits not zero");
  a_glob_zero: assert property (rdGl |=> rdata[7:4] == 4'h0)
    else $error("global upper bits not zero");
  a_arm_clear: assert property (wrArm && pinOut |=> !alertPinPort)
    else $error("arm did not clear alert");
  a_alert_hold: assert property (alertPinPort && pinOut && !mkAcc && !wrArm ##1 pinOut
    |-> alertPinPort) else $error("alert dropped");
  a_mask_flag: assert property (rdMk && alertPinPort |=> rdata[MASK_ALERT_BIT])
    else $error("mask read missed alert");
  a_mask_clear: assert property (alertPinPort && mkAcc && !wrArm |=> !alertPinPort)
    else $error("mask access did not clear alert");
  a_pin_mode: assert property (alertPinOe_n == !pinOut && (pinOut || !alertPinPort))
    else $error("alert pin mode wrong");
  // Main scenarios
  cover property (wrArm);
  cover property ($rose(alertPinPort));
  cover property (rdMk ##1 rdata[MASK_ALERT_BIT]);
endmodule
bind pecd_top pecd_sva u_sva (.sys_clk, .arst_n, .acc, .rdata, .portMode, .alertPinPort, .alertPinOe_n,
  .shutdown);

// File: pecd_host.sv
// Host model: issues register accesses to the block
// Assumes read data is registered and valid the cycle after the strobe
module pecd_host
  import pecd_pkg::*;
(
  // Clock and bus
  input  wire logic       sys_clk,
  input  wire logic [7:0] rdata,
  output pecd_access_t    acc
);
  timeunit 1ns;
  timeprecision 1ns;
  initial acc = '0;
  // One access; released lines show the inverse of the last value
  task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(posedge sys_clk);
    acc <= '{w, !w, a, d};
    @(posedge sys_clk);
    acc <= '{1'b0, 1'b0, ~a, ~d};
    #1 q = rdata;
  endtask
  // Mask first, then arm; the bench sets the alert pin mode beforehand
  task automatic arm(input logic [6:0] m);
    logic [7:0] q;
    xfer(1'b1, ADDR_MASK, {1'b0, m}, q);
    xfer(1'b1, ADDR_DEVICE_CFG, 8'h81, q);
  endtask
endmodule

// File: tb.sv
// Bench: register rows, drive selection, change detection, reset
// Assumes the host model carries every register access
module tb
  import pecd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [7:0] a, d, r; logic sd;} pecd_row_t;
  logic               sys_clk, arst_n, shutdown, alertPinPort, alertPinOe_n;
  logic [7:0]         rdata, q;
  logic [6:0]         monitoredPorts;
  logic [1:0]         portMode [NUM_SEG];
  logic [NUM_SEG-1:0] portData, ledOn;
  logic [3:0]         ledLevel [NUM_SEG];
  pecd_access_t       acc;
  int                 num_errors, n_checks, cyc;
  pecd_row_t          rows [5] = '{'{8'h04, 8'h3E, 8'h00, 1}, '{8'h04, 8'h41, 8'h41, 0},
    '{8'h02, 8'hFF, 8'h0F, 0}, '{8'h02, 8'hA5, 8'h05, 0}, '{8'h30, 8'hFF, 8'h00, 0}};
  pecd_host host (.sys_clk, .rdata, .acc);
  pecd_top dut (.sys_clk, .arst_n, .acc, .rdata, .monitoredPorts, .portMode, .portData, .alertPinPort,
    .alertPinOe_n, .shutdown, .ledOn, .ledLevel);
  ////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial
  begin
    sys_clk = 0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      num_errors++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////
  // Helpers
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a);
    host.xfer(1'b0, a, 8'h00, q);
  endtask
  task automatic ports(input logic [6:0] v);
    @(posedge sys_clk) monitoredPorts <= v;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    arst_n = 0; cyc = 0; num_errors = 0; n_checks = 0;
    monitoredPorts = 7'h55;
    portData = 28'h000_0001; // First LED port lit while running
    foreach (portMode[i]) portMode[i] = MODE_LED;
    portMode[27] = MODE_OUT;
    portMode[20] = MODE_OUT;
    repeat (12) @(posedge sys_clk);
    chk("shutdown", shutdown, 1);
    arst_n <= 1;
    repeat (3) @(posedge sys_clk);
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk("rdata", q, rows[i].r);
      chk("shutdown", shutdown, rows[i].sd);
    end
    $display("test rows done");
    wr(8'h12, 8'h3C); wr(8'h04, 8'h41);
    rd(8'h12); chk("seg", q, 8'h3C);
    chk("ledLevel0", ledLevel[0], 4'hC);
    chk("ledLevel1", ledLevel[1], 4'h3);
    wr(8'h04, 8'h01);
    chk("ledLevel0", ledLevel[0], 4'h5);
    wr(ADDR_DISP_TEST, 8'h01);
    chk("ledLevel0", ledLevel[0], 4'h7);
    chk("ledOn0", ledOn[0], 1);
    chk("ledOn20", ledOn[20], 0);
    wr(ADDR_DISP_TEST, 8'h00);
    chk("ledOn0", ledOn[0], 1);
    chk("ledLevel0", ledLevel[0], 4'h5);
    $display("test drive done");
    host.arm(7'h7F);
    chk("alert", alertPinPort, 0);
    chk("oe", alertPinOe_n, 0);
    @(posedge sys_clk) monitoredPorts <= 7'h54;
    ports(7'h55);
    chk("alert", alertPinPort, 1);
    @(posedge sys_clk) portMode[27] <= MODE_LED;
    @(negedge sys_clk);
    chk("alert", alertPinPort, 0);
    chk("oe", alertPinOe_n, 1);
    @(posedge sys_clk) portMode[27] <= MODE_OUT;
    rd(ADDR_MASK); chk("mask", q, 8'hFF);
    rd(ADDR_MASK); chk("mask", q, 8'h7F);
    ports(7'h00);
    chk("alert", alertPinPort, 0);
    rd(ADDR_DEVICE_CFG); chk("cfg", q, 8'h81);
    host.arm(7'h7E);
    ports(7'h01);
    chk("alert", alertPinPort, 0);
    ports(7'h03);
    chk("alert", alertPinPort, 1);
    rd(ADDR_MASK); chk("mask", q, 8'hFE);
    host.arm(7'h7F);
    ports(7'h06);
    wr(ADDR_DEVICE_CFG, 8'h81);
    repeat (2) @(posedge sys_clk);
    chk("alert", alertPinPort, 0);
    wr(ADDR_DEVICE_CFG, 8'h01);
    ports(7'h00);
    chk("alert", alertPinPort, 0);
    rd(ADDR_MASK); chk("mask", q, 8'h7F);
    $display("test detect done");
    @(posedge sys_clk) arst_n <= 0;
    repeat (2) @(posedge sys_clk);
    chk("shutdown", shutdown, 1);
    chk("ledOn0", ledOn[0], 0);
    @(posedge sys_clk) arst_n <= 1;
    repeat (3) @(posedge sys_clk);
    rd(ADDR_DEVICE_CFG); chk("cfg", q, 8'h00);
    rd(ADDR_GLOBAL_DRIVE); chk("global", q, 8'h00);
    $display("test reset done");
    close_out();
  end
endmodule
